// file: rtl/burst_prot_pkg.sv
// Shared constants and types for the burst mode and protection controller
`default_nettype none
package burst_prot_pkg;

   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;

   localparam int BURST_ENTRY_BLANKING_MS = 24;
   localparam int BURST_ENTRY_BLANKING_CYC = BURST_ENTRY_BLANKING_MS * (CLK_HZ / 1000);
   localparam int OVERLOAD_BLANKING_MS = 30;
   localparam int OVERLOAD_BLANKING_CYC = OVERLOAD_BLANKING_MS * (CLK_HZ / 1000);
   localparam int SUPPLY_OV_QUAL_US = 10;
   localparam int SUPPLY_OV_QUAL_CYC = SUPPLY_OV_QUAL_US * (CLK_HZ / 1_000_000);
   localparam int OUTPUT_OVERVOLTAGE_BLANKING_US = 100;
   localparam int OUTPUT_OVERVOLTAGE_BLANKING_CYC =
      OUTPUT_OVERVOLTAGE_BLANKING_US * (CLK_HZ / 1_000_000);
   // Least time: rounded up to whole cycles
   localparam int SHORT_WINDING_BLANKING_NS = 190;
   localparam int SHORT_WINDING_BLANKING_CYC =
      (SHORT_WINDING_BLANKING_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // Longest on-time: rounded down
   localparam int MAX_ON_LIMIT_US = 30;
   localparam int MAX_ON_LIMIT_CYC = MAX_ON_LIMIT_US * (CLK_HZ / 1_000_000);
   localparam int BURST_SWITCH_FREQUENCY_HZ = 52_000;
   localparam int BURST_PERIOD_CYC = CLK_HZ / BURST_SWITCH_FREQUENCY_HZ;
   localparam int BURST_MAX_DUTY_PCT = 50;
   localparam int BURST_MAX_ON_CYC = BURST_PERIOD_CYC * BURST_MAX_DUTY_PCT / 100;

   // ------------------------------------------------------------
   // Valley counter
   // ------------------------------------------------------------
   localparam int VALLEY_W = 3;
   localparam logic [2:0] BURST_ENTRY_VALLEY_COUNT = 3'h7;
   localparam logic [2:0] VALLEY_RELOAD_VALUE = 3'h1;

   // ------------------------------------------------------------
   // Comparator input bit positions
   // ------------------------------------------------------------
   localparam int CMP_W = 12;
   localparam int CMP_FB_ENTRY = 0;
   localparam int CMP_FB_RESUME = 1;
   localparam int CMP_FB_PAUSE = 2;
   localparam int CMP_FB_EXIT = 3;
   localparam int CMP_CS_BURST = 4;
   localparam int CMP_CS_SHORT = 5;
   localparam int CMP_ZC_OV = 6;
   localparam int CMP_VCC_OFF = 7;
   localparam int CMP_VCC_ON = 8;
   localparam int CMP_VCC_OV = 9;
   localparam int CMP_VCC_PD = 10;
   localparam int CMP_OVERTEMP = 11;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] FAULT_ADDR = 8'h08;
   localparam int CTRL_BURST_ALLOW_BIT = 0;
   localparam logic CTRL_BURST_ALLOW_RESET = 1'b1;
   localparam int FAULT_W = 6;
   localparam int FAULT_UV = 0;
   localparam int FAULT_VCC_OV = 1;
   localparam int FAULT_OVERLOAD = 2;
   localparam int FAULT_OVERTEMP = 3;
   localparam int FAULT_OUT_OV = 4;
   localparam int FAULT_SHORT = 5;
   localparam int STATUS_STATE_LSB = 0;
   localparam int STATUS_GATE_BIT = 4;
   localparam int STATUS_STARTUP_BIT = 5;

   typedef enum logic [2:0] {
      STARTUP,
      RUN_NORMAL,
      BURST_PAUSE,
      BURST_SWITCH,
      AUTO_RESTART,
      LATCHED
   } ctrl_state_type;

endpackage
`default_nettype wire

// file: rtl/comparator_sync.sv
// Two-flop synchroniser for the comparator outputs
`default_nettype none
module comparator_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] sync
);
   logic [WIDTH-1:0] stage;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (srst) begin
         stage <= '0;
         sync <= '0;
      end else begin
         stage <= async;
         sync <= stage;
      end
   end
endmodule
`default_nettype wire

// file: rtl/qual_timer.sv
// Qualification timer: flags a condition held for COUNT cycles
`default_nettype none
module qual_timer #(
   parameter int COUNT = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic cond,
   output logic done
);
   localparam int W = $clog2(COUNT + 1);
   localparam logic [W-1:0] LIMIT = W'(COUNT);

   logic [W-1:0] count;

   // Any drop of the condition starts the wait over
   always_ff @(posedge clk) begin
      if (srst || !cond) begin
         count <= '0;
      end else if (count != LIMIT) begin
         count <= count + W'(1);
      end
   end

   assign done = cond && (count == LIMIT);
endmodule
`default_nettype wire

// file: rtl/burst_prot_ctrl.sv
// Burst mode switching and protection supervisor of a flyback controller
//
// Contract
// - Enter burst when feedback low and valley count 7, both held 24 ms.
// - In burst pause, feedback above resume level restores bias and switching.
// - Burst turn-on comes from a fixed 52 kHz timer.
// - Burst on-pulse ends when current reaches the burst peak level.
// - Burst on-pulse also ends at 50% duty; first terminator wins.
// - Feedback at pause level removes bias and stops burst switching.
// - Feedback above exit level leaves burst and restores full current limit.
// - On leaving burst, load the valley counter with one.
// - Supply undervoltage or overvoltage resets control and holds switch off; overvoltage here acts only in normal mode, via the 10 us auto-restart.
// - Below turn-off enable startup cell; above turn-on restart with soft-start.
// - Supply overvoltage held 10 us in normal mode gives auto-restart.
// - Feedback above overload level for 30 ms gives auto-restart.
// - Controller over-temperature gives auto-restart.
// - Overload, over-temperature and short-winding checks are off in burst.
// - Zero-cross overvoltage held 100 us during off-time latches off.
// - Only supply power-down releases the latched-off state.
// - Short-winding current held past 190 ns during on-time latches off.
// - While latched, startup cell cycles between turn-off and turn-on levels.
// - Gate high beyond the maximum on-time is turned off at once.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`default_nettype none
module burst_prot_ctrl
   import burst_prot_pkg::*;
#(
   parameter int ENTRY_BLANKING_CYC = BURST_ENTRY_BLANKING_CYC,
   parameter int OVERLOAD_CYC = OVERLOAD_BLANKING_CYC,
   parameter int OUTPUT_OV_CYC = OUTPUT_OVERVOLTAGE_BLANKING_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic fbBelowEntry,
   input wire logic fbAboveResume,
   input wire logic fbBelowPause,
   input wire logic fbAboveExit,
   input wire logic csBurstPeak,
   input wire logic csShortWinding,
   input wire logic zcOverVoltage,
   input wire logic supplyBelowOff,
   input wire logic supplyAboveOn,
   input wire logic supplyOverVoltage,
   input wire logic supplyPowerDown,
   input wire logic overTemp,
   input wire logic normalGateReq,
   input wire logic [2:0] valleyCount,
   output logic gateDrive,
   output logic startupCellOn,
   output logic biasEnable,
   output logic burstActive,
   output logic fullCurrentLimit,
   output logic softStartPulse,
   output logic valleyLoad,
   output logic [2:0] valleyLoadValue,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata
);

   // ------------------------------------------------------------
   // Input synchronisation
   // ------------------------------------------------------------
   logic [CMP_W-1:0] cmpRaw;
   logic [CMP_W-1:0] cmp;

   assign cmpRaw[CMP_FB_ENTRY] = fbBelowEntry;
   assign cmpRaw[CMP_FB_RESUME] = fbAboveResume;
   assign cmpRaw[CMP_FB_PAUSE] = fbBelowPause;
   assign cmpRaw[CMP_FB_EXIT] = fbAboveExit;
   assign cmpRaw[CMP_CS_BURST] = csBurstPeak;
   assign cmpRaw[CMP_CS_SHORT] = csShortWinding;
   assign cmpRaw[CMP_ZC_OV] = zcOverVoltage;
   assign cmpRaw[CMP_VCC_OFF] = supplyBelowOff;
   assign cmpRaw[CMP_VCC_ON] = supplyAboveOn;
   assign cmpRaw[CMP_VCC_OV] = supplyOverVoltage;
   assign cmpRaw[CMP_VCC_PD] = supplyPowerDown;
   assign cmpRaw[CMP_OVERTEMP] = overTemp;

   comparator_sync #(
      .WIDTH(CMP_W)
   ) inputSync (
      .clk(clk),
      .srst(srst),
      .async(cmpRaw),
      .sync(cmp)
   );

   // ------------------------------------------------------------
   // State and qualification timers
   // ------------------------------------------------------------
   ctrl_state_type state;
   ctrl_state_type next_state;
   logic burstAllow;
   logic inBurst;
   logic entryDone;
   logic supplyOvDone;
   logic overloadDone;
   logic outOvDone;
   logic shortDone;
   logic running;

   assign inBurst = (state == BURST_PAUSE) || (state == BURST_SWITCH);
   assign running = (state == RUN_NORMAL) || inBurst;

   // Entry conditions held for the blanking time
   qual_timer #(
      .COUNT(ENTRY_BLANKING_CYC)
   ) entryTimer (
      .clk(clk),
      .srst(srst),
      .cond(state == RUN_NORMAL && burstAllow && cmp[CMP_FB_ENTRY]
            && valleyCount == BURST_ENTRY_VALLEY_COUNT),
      .done(entryDone)
   );

   // Supply overvoltage qualified in normal mode only
   qual_timer #(
      .COUNT(SUPPLY_OV_QUAL_CYC)
   ) supplyOvTimer (
      .clk(clk),
      .srst(srst),
      .cond(state == RUN_NORMAL && cmp[CMP_VCC_OV]),
      .done(supplyOvDone)
   );

   qual_timer #(
      .COUNT(OVERLOAD_CYC)
   ) overloadTimer (
      .clk(clk),
      .srst(srst),
      .cond(state == RUN_NORMAL && cmp[CMP_FB_EXIT]),
      .done(overloadDone)
   );

   // Output overvoltage watched during off-time only
   qual_timer #(
      .COUNT(OUTPUT_OV_CYC)
   ) outOvTimer (
      .clk(clk),
      .srst(srst),
      .cond(running && !gateDrive && cmp[CMP_ZC_OV]),
      .done(outOvDone)
   );

   // Short winding during on-time; masked during burst
   qual_timer #(
      .COUNT(SHORT_WINDING_BLANKING_CYC)
   ) shortTimer (
      .clk(clk),
      .srst(srst),
      .cond(state == RUN_NORMAL && gateDrive && cmp[CMP_CS_SHORT]),
      .done(shortDone)
   );

   // ------------------------------------------------------------
   // Supervisor state machine
   // ------------------------------------------------------------
   logic autoRestartEvt;
   logic latchEvt;

   // Over-temperature acts at once; not in burst
   assign autoRestartEvt = supplyOvDone || overloadDone
                           || (state == RUN_NORMAL && cmp[CMP_OVERTEMP]);
   assign latchEvt = outOvDone || shortDone;

   always_comb begin
      next_state = state;
      unique case (state)
         STARTUP: begin
            // Fresh start once supply is above turn-on
            if (cmp[CMP_VCC_ON]) begin
               next_state = RUN_NORMAL;
            end
         end
         RUN_NORMAL, BURST_PAUSE, BURST_SWITCH: begin
            if (latchEvt) begin
               next_state = LATCHED;
            end else if (cmp[CMP_VCC_OFF]) begin
               next_state = STARTUP;
            end else if (autoRestartEvt) begin
               // Overvoltage also lands here via the qualified event
               next_state = AUTO_RESTART;
            end else if (state == RUN_NORMAL) begin
               if (entryDone) begin
                  next_state = BURST_PAUSE;
               end
            end else if (cmp[CMP_FB_EXIT]) begin
               next_state = RUN_NORMAL;
            end else if (state == BURST_PAUSE && cmp[CMP_FB_RESUME]) begin
               next_state = BURST_SWITCH;
            end else if (state == BURST_SWITCH && cmp[CMP_FB_PAUSE]) begin
               next_state = BURST_PAUSE;
            end
         end
         AUTO_RESTART: begin
            // Wait for the supply to collapse, then recharge from startup
            if (cmp[CMP_VCC_OFF]) begin
               next_state = STARTUP;
            end
         end
         LATCHED: begin
            next_state = LATCHED;
         end
         default: begin
            next_state = STARTUP;
         end
      endcase
      // Power-down is the only way out of the latch
      if (cmp[CMP_VCC_PD]) begin
         next_state = STARTUP;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state <= STARTUP;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         softStartPulse <= 1'b0;
         valleyLoad <= 1'b0;
      end else begin
         softStartPulse <= (state == STARTUP) && (next_state == RUN_NORMAL);
         valleyLoad <= inBurst && (next_state == RUN_NORMAL);
      end
   end

   assign valleyLoadValue = VALLEY_RELOAD_VALUE;

   // ------------------------------------------------------------
   // Startup cell hysteresis
   // ------------------------------------------------------------
   logic charging;

   // Cell on at turn-off level, off at turn-on level
   always_ff @(posedge clk) begin
      if (srst) begin
         charging <= 1'b1;
      end else if (cmp[CMP_VCC_OFF]) begin
         charging <= 1'b1;
      end else if (cmp[CMP_VCC_ON]) begin
         charging <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Burst PWM timer
   // ------------------------------------------------------------
   localparam int PW = $clog2(BURST_PERIOD_CYC);
   localparam logic [PW-1:0] PERIOD_LAST = PW'(BURST_PERIOD_CYC - 1);
   localparam logic [PW-1:0] DUTY_LIMIT = PW'(BURST_MAX_ON_CYC);

   logic [PW-1:0] burstPhase;

   always_ff @(posedge clk) begin
      if (srst || state != BURST_SWITCH || burstPhase == PERIOD_LAST) begin
         burstPhase <= '0;
      end else begin
         burstPhase <= burstPhase + PW'(1);
      end
   end

   // ------------------------------------------------------------
   // Gate drive
   // ------------------------------------------------------------
   localparam int OW = $clog2(MAX_ON_LIMIT_CYC + 1);
   localparam logic [OW-1:0] ON_LIMIT = OW'(MAX_ON_LIMIT_CYC);

   logic [OW-1:0] onTime;
   logic onExpired;
   logic normalBlock;
   logic next_gate;

   assign onExpired = gateDrive && (onTime == ON_LIMIT);

   always_ff @(posedge clk) begin
      if (srst || !gateDrive) begin
         onTime <= '0;
      end else if (onTime != ON_LIMIT) begin
         onTime <= onTime + OW'(1);
      end
   end

   // Holds normal gating off until the request itself drops
   always_ff @(posedge clk) begin
      if (srst || !normalGateReq) begin
         normalBlock <= 1'b0;
      end else if (onExpired) begin
         normalBlock <= 1'b1;
      end
   end

   always_comb begin
      next_gate = 1'b0;
      if (next_state == RUN_NORMAL && state == RUN_NORMAL) begin
         next_gate = normalGateReq && !normalBlock;
      end else if (next_state == BURST_SWITCH && state == BURST_SWITCH) begin
         if (burstPhase == PERIOD_LAST) begin
            next_gate = 1'b1;
         end else if (gateDrive) begin
            // Current peak or duty limit, whichever first
            next_gate = !cmp[CMP_CS_BURST] && (burstPhase < DUTY_LIMIT - PW'(1));
         end
      end
      if (onExpired) begin
         next_gate = 1'b0;
      end
   end

   // Any state change drops the gate
   always_ff @(posedge clk) begin
      if (srst) begin
         gateDrive <= 1'b0;
      end else begin
         gateDrive <= next_gate;
      end
   end

   // ------------------------------------------------------------
   // Status outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         startupCellOn <= 1'b1;
         biasEnable <= 1'b0;
         burstActive <= 1'b0;
         fullCurrentLimit <= 1'b1;
      end else begin
         startupCellOn <= charging && !(next_state == RUN_NORMAL || next_state == BURST_PAUSE
                                        || next_state == BURST_SWITCH);
         biasEnable <= next_state == RUN_NORMAL || next_state == BURST_SWITCH;
         burstActive <= next_state == BURST_PAUSE || next_state == BURST_SWITCH;
         fullCurrentLimit <= !(next_state == BURST_PAUSE || next_state == BURST_SWITCH);
      end
   end

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   logic [FAULT_W-1:0] faults;
   logic [FAULT_W-1:0] faultSet;
   logic [FAULT_W-1:0] faultClr;

   assign faultSet[FAULT_UV] = running && cmp[CMP_VCC_OFF];
   assign faultSet[FAULT_VCC_OV] = supplyOvDone;
   assign faultSet[FAULT_OVERLOAD] = overloadDone;
   assign faultSet[FAULT_OVERTEMP] = state == RUN_NORMAL && cmp[CMP_OVERTEMP];
   assign faultSet[FAULT_OUT_OV] = outOvDone;
   assign faultSet[FAULT_SHORT] = shortDone;
   assign faultClr = (regWrite && regAddr == FAULT_ADDR) ? regWdata[FAULT_W-1:0] : '0;

   // Sticky causes; a new event beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         faults <= '0;
      end else begin
         faults <= (faults & ~faultClr) | faultSet;
      end
   end

   // Software may forbid burst entry
   always_ff @(posedge clk) begin
      if (srst) begin
         burstAllow <= CTRL_BURST_ALLOW_RESET;
      end else if (regWrite && regAddr == CTRL_ADDR) begin
         burstAllow <= regWdata[CTRL_BURST_ALLOW_BIT];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         regRdata <= '0;
      end else begin
         regRdata <= '0;
         if (regRead) begin
            unique case (regAddr)
               CTRL_ADDR: begin
                  regRdata[CTRL_BURST_ALLOW_BIT] <= burstAllow;
               end
               STATUS_ADDR: begin
                  regRdata[STATUS_STATE_LSB +: 3] <= state;
                  regRdata[STATUS_GATE_BIT] <= gateDrive;
                  regRdata[STATUS_STARTUP_BIT] <= startupCellOn;
               end
               FAULT_ADDR: begin
                  regRdata[FAULT_W-1:0] <= faults;
               end
               default: begin
                  regRdata <= '0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// file: bench/gate_driver_model.sv
// Far-side model: current sense ramps to the burst peak a set time after turn-on
`default_nettype none
module gate_driver_model (
   input wire logic clk,
   input wire logic gateDrive,
   input wire logic [9:0] peakDelay,
   output logic csBurstPeak
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] onTime = 10'h000;
   // A long peak delay lets the duty limit end the pulse before the current does
   always @(posedge clk) begin
      onTime <= gateDrive ? onTime + 10'h001 : 10'h000;
   end
   assign csBurstPeak = gateDrive && (onTime >= peakDelay);
endmodule
`default_nettype wire

// file: bench/burst_prot_checker.sv
// Port-level checks for the burst mode and protection controller
`default_nettype none
module burst_prot_checker
   import burst_prot_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic fbBelowPause,
   input wire logic fbAboveExit,
   input wire logic csBurstPeak,
   input wire logic csShortWinding,
   input wire logic supplyBelowOff,
   input wire logic gateDrive,
   input wire logic startupCellOn,
   input wire logic biasEnable,
   input wire logic burstActive,
   input wire logic fullCurrentLimit,
   input wire logic softStartPulse,
   input wire logic valleyLoad,
   input wire logic [2:0] valleyLoadValue
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] onCnt;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   always_ff @(posedge clk) begin
      onCnt <= (srst || !gateDrive) ? 12'h000 : onCnt + 12'h001;
   end
   sequence burstLeft;
      burstActive ##1 !burstActive && fbAboveExit;
   endsequence
   sequence shortHeld;
      (csShortWinding && gateDrive && !burstActive)[*8] ##1 csShortWinding[*7];
   endsequence
   // --------------------------------------------
   // Checks
   // --------------------------------------------
   a_peak_ends_pulse:
      assert property (burstActive && gateDrive && csBurstPeak |-> ##[1:5] !gateDrive)
      else $error("burst pulse outlived peak current");
   a_burst_duty_cap:
      assert property (burstActive && gateDrive |-> onCnt <= BURST_MAX_ON_CYC + 3)
      else $error("burst pulse too long");
   a_on_time_cap:
      assert property (gateDrive |-> onCnt <= MAX_ON_LIMIT_CYC + 3)
      else $error("on-time limit missed");
   a_uv_holds_off:
      assert property (supplyBelowOff[*6] |-> !gateDrive && startupCellOn)
      else $error("undervoltage did not stop switching");
   a_pause_stops_bias:
      assert property ((burstActive && fbBelowPause)[*6] |-> !biasEnable && !gateDrive)
      else $error("burst pause kept bias");
   a_exit_loads_valley:
      assert property (burstLeft |-> ##[0:3] valleyLoad && valleyLoadValue == 3'h1)
      else $error("no valley reload on burst exit");
   a_limit_follows_burst:
      assert property ($stable(burstActive)[*3] |-> fullCurrentLimit != burstActive)
      else $error("current limit mismatch");
   a_short_latches_off:
      assert property (shortHeld |-> ##[0:4] !gateDrive)
      else $error("short winding not latched");
   // Soft-start pulse marks a fresh start into normal switching
   a_soft_start_once:
      assert property (softStartPulse |-> biasEnable && !burstActive && !startupCellOn
                       ##1 !softStartPulse)
      else $error("soft-start pulse malformed");
endmodule
bind burst_prot_ctrl burst_prot_checker i_chk (.*);
`default_nettype wire

// file: bench/burst_mode_and_protection_ctrl_bench.sv
// Self-checking bench for the burst mode and protection controller
`default_nettype none
module burst_mode_and_protection_ctrl_bench
   import burst_prot_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic fbBelowEntry = 1'b0, fbAboveResume = 1'b0, fbBelowPause = 1'b0;
   logic fbAboveExit = 1'b0, csShortWinding = 1'b0, zcOverVoltage = 1'b0;
   logic supplyBelowOff = 1'b0, supplyAboveOn = 1'b0, supplyOverVoltage = 1'b0;
   logic supplyPowerDown = 1'b0, overTemp = 1'b0, normalGateReq = 1'b0;
   logic regWrite = 1'b0, regRead = 1'b0, rdSeen = 1'b0;
   logic [2:0] valleyCount = 3'h0;
   logic [7:0] regAddr = 8'h00;
   logic [9:0] peakDelay = 10'h064;
   logic [31:0] regWdata = 32'h0;
   logic gateDrive, startupCellOn, biasEnable, burstActive, fullCurrentLimit;
   logic softStartPulse, valleyLoad, csBurstPeak;
   logic [2:0] valleyLoadValue;
   logic [31:0] regRdata;
   logic [63:0] expQ[$];
   logic [63:0] note;
   integer seed = 32'hE0EA;
   int errors = 0;
   int checks = 0;
   // Short blanking counts keep the run brief
   burst_prot_ctrl #(.ENTRY_BLANKING_CYC(50), .OVERLOAD_CYC(50), .OUTPUT_OV_CYC(40)) i_dut (.*);
   gate_driver_model i_far (.clk, .gateDrive, .peakDelay, .csBurstPeak);
   initial forever #10 clk = ~clk;
   // Read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      rdSeen <= regRead;
      if (rdSeen) begin
         note = expQ.pop_front();
         checks++;
         if ((regRdata & note[63:32]) !== note[31:0]) begin
            errors++;
            $display("[ERR] %0t read %h want %h", $time, regRdata, note[31:0]);
         end
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      expQ.push_back({m, e});
      @(posedge clk);
      regRead <= 1'b0;
   endtask
   task automatic st(input logic [31:0] e);
      rd(STATUS_ADDR, 32'h7, e);
   endtask
   task automatic restart();
      supplyBelowOff <= 1'b1;
      tick(8);
      supplyBelowOff <= 1'b0;
      supplyAboveOn <= 1'b1;
      tick(8);
      supplyAboveOn <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // --------------------------------------------
   // Stimulus
   // --------------------------------------------
   initial begin
      tick(6);
      srst <= 1'b0;
      rd(CTRL_ADDR, 32'h1, 32'h1);
      rd(STATUS_ADDR, 32'h37, 32'h20);
      wr(8'h0C, 32'hFFFFFFFF);
      rd(8'h0C, 32'hFFFFFFFF, 32'h0);
      restart();
      st(32'h1);
      fbAboveExit <= 1'b1;
      tick(40);
      fbAboveExit <= 1'b0;
      tick(3);
      fbAboveExit <= 1'b1;
      tick(40);
      st(32'h1);
      tick(20);
      fbAboveExit <= 1'b0;
      st(32'h4);
      rd(FAULT_ADDR, 32'h4, 32'h4);
      wr(FAULT_ADDR, 32'h3F);
      restart();
      supplyOverVoltage <= 1'b1;
      tick(300);
      st(32'h1);
      tick(220);
      supplyOverVoltage <= 1'b0;
      st(32'h4);
      restart();
      overTemp <= 1'b1;
      tick(5);
      overTemp <= 1'b0;
      st(32'h4);
      restart();
      valleyCount <= 3'($random(seed)) & 3'h6;
      fbBelowEntry <= 1'b1;
      tick(80);
      st(32'h1);
      valleyCount <= 3'h7;
      tick(30);
      fbBelowEntry <= 1'b0;
      tick(3);
      fbBelowEntry <= 1'b1;
      tick(40);
      st(32'h1);
      tick(20);
      fbBelowEntry <= 1'b0;
      st(32'h2);
      overTemp <= 1'b1;
      supplyOverVoltage <= 1'b1;
      tick(600);
      overTemp <= 1'b0;
      supplyOverVoltage <= 1'b0;
      st(32'h2);
      fbAboveResume <= 1'b1;
      peakDelay <= 10'h064 + 10'($random(seed) & 63);
      tick(4);
      st(32'h3);
      tick(2000);
      peakDelay <= 10'h258;
      tick(2000);
      fbAboveResume <= 1'b0;
      fbBelowPause <= 1'b1;
      tick(6);
      rd(STATUS_ADDR, 32'h17, 32'h2);
      fbBelowPause <= 1'b0;
      fbAboveExit <= 1'b1;
      tick(10);
      fbAboveExit <= 1'b0;
      st(32'h1);
      normalGateReq <= 1'b1;
      tick(1600);
      normalGateReq <= 1'b0;
      tick(4);
      normalGateReq <= 1'b1;
      tick(4);
      csShortWinding <= 1'b1;
      tick(20);
      csShortWinding <= 1'b0;
      normalGateReq <= 1'b0;
      st(32'h5);
      supplyPowerDown <= 1'b1;
      tick(6);
      supplyPowerDown <= 1'b0;
      st(32'h0);
      restart();
      zcOverVoltage <= 1'b1;
      tick(60);
      zcOverVoltage <= 1'b0;
      st(32'h5);
      supplyBelowOff <= 1'b1;
      tick(8);
      rd(STATUS_ADDR, 32'h37, 32'h25);
      supplyBelowOff <= 1'b0;
      supplyAboveOn <= 1'b1;
      tick(8);
      rd(STATUS_ADDR, 32'h37, 32'h5);
      supplyAboveOn <= 1'b0;
      supplyPowerDown <= 1'b1;
      tick(6);
      supplyPowerDown <= 1'b0;
      st(32'h0);
      tick(4);
      print_verdict();
   end
   initial begin
      tick(20000);
      errors++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
`default_nettype wire
